// ==== src/qesm_pkg.sv ====
package qesm_pkg;
  localparam logic [3:0] TYPE_OFF = 4'h0;
  localparam logic [3:0] TYPE_AB = 4'h2;
  localparam logic [3:0] TYPE_ABZ = 4'hc;
  localparam logic [4:0] CTRL_VC_ENC = 5'h15;
  localparam logic [4:0] CTRL_TVC_ENC = 5'h17;
  localparam int CLK_HZ = 100000000;
  localparam int GATE_US = 100;
  localparam int GATE_CYCLES = CLK_HZ / 1000000 * GATE_US;
  // rpm of one edge per gate at one pulse per revolution
  localparam int SPEED_SCALE = 60 * 1000000 / (4 * GATE_US);
  localparam int SPEED_W = 16;
  localparam int POS_W = 32;
  localparam logic [3:0] ADDR_CFG = 4'h0;
  localparam logic [3:0] ADDR_PPR = 4'h1;
  localparam logic [3:0] ADDR_DEV = 4'h2;
  localparam logic [3:0] ADDR_DLY = 4'h3;
  localparam logic [3:0] ADDR_CALC = 4'h4;
  localparam logic [3:0] ADDR_SPEED = 4'h5;
  localparam logic [3:0] ADDR_POS = 4'h6;
  localparam logic [3:0] ADDR_STAT = 4'h7;
  localparam logic [3:0] ADDR_IRQ = 4'h8;
  localparam logic [3:0] ADDR_MASK = 4'h9;
  localparam int CFG_TYPE_LSB = 0;
  localparam int CFG_CTRL_LSB = 4;
  localparam int CFG_INV_BIT = 9;
  localparam int CFG_RESP_BIT = 10;
  localparam int CFG_CLR_BIT = 11;
  localparam int IRQ_W = 3;
  localparam int IRQ_ZERO = 0;
  localparam int IRQ_FAULT = 1;
  localparam int IRQ_ALARM = 2;
  localparam logic [15:0] PPR_RST = 16'h0400;
  localparam logic [15:0] DLY_RST = 16'h000a;
  localparam logic [15:0] DEV_RST = 16'h0064;
  typedef enum logic [1:0] {QESM_RUN = 2'b00, QESM_PEND = 2'b01, QESM_FAULT = 2'b11,
                            QESM_FALLBACK = 2'b10} qesm_state_t;
  typedef struct packed {
    logic [3:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } qesm_bus_t;
endpackage

// ==== src/qesm_top.sv ====
// Local design decisions: the register offsets and the strobed register port.
`timescale 1ns/100ps
module qesm_top (
  input wire logic sys_clk_i, // system clock
  input wire logic rst_i, // async reset, high
  input wire logic ce_i, // clock enable
  input wire qesm_pkg::qesm_bus_t bus_i, // register access
  output logic [31:0] rdata_o, // read data
  input wire logic track_a_positive_i, // track a pin
  input wire logic track_b_positive_i, // track b pin
  input wire logic zero_pulse_positive_i, // zero pin
  output logic signed [15:0] speed_o, // encoder speed, rpm
  output logic use_encoder_o, // encoder feedback in use
  output logic sensorless_vector_control_o, // fallback active
  output logic encoder_vector_control_o, // encoder control active
  output logic encoder_loss_fault_o, // shutdown fault
  output logic alarm_o, // loss alarm
  output logic zero_flag_o, // zero pulse seen, pulse
  output logic irq_o // interrupt
);
  logic [11:0] cfg;
  logic [15:0] ppr;
  logic [15:0] dev;
  logic [15:0] dly;
  logic signed [15:0] calc;
  logic [2:0] irq_st;
  logic [2:0] irq_mask;
  logic [11:0] next_cfg;
  logic [15:0] next_ppr;
  logic [15:0] next_dev;
  logic [15:0] next_dly;
  logic signed [15:0] next_calc;
  logic [2:0] next_irq_st;
  logic [2:0] next_irq_mask;
  logic [31:0] next_rdata;
  logic [2:0] s1;
  logic [2:0] s2;
  logic [2:0] s3;
  logic signed [31:0] pos;
  logic signed [31:0] next_pos;
  logic signed [15:0] win_cnt;
  logic signed [15:0] next_win_cnt;
  logic [31:0] gate;
  logic [31:0] next_gate;
  logic signed [15:0] next_speed;
  logic zero_flag;
  logic next_zero_flag;
  qesm_pkg::qesm_state_t state;
  qesm_pkg::qesm_state_t next_state;
  logic [15:0] dly_cnt;
  logic [15:0] next_dly_cnt;
  logic [3:0] enc_type;
  logic [4:0] ctrl_type;
  logic eval_on;
  logic zero_on;
  logic ctrl_enc;
  logic step;
  logic dir_up;
  logic signed [16:0] diff;
  logic [16:0] adiff;
  logic loss;
  logic sec_tick;

  assign enc_type = cfg[qesm_pkg::CFG_TYPE_LSB +: 4];
  assign ctrl_type = cfg[qesm_pkg::CFG_CTRL_LSB +: 5];
  assign eval_on = (enc_type == qesm_pkg::TYPE_AB) || (enc_type == qesm_pkg::TYPE_ABZ);
  assign zero_on = enc_type == qesm_pkg::TYPE_ABZ;
  assign ctrl_enc = (ctrl_type == qesm_pkg::CTRL_VC_ENC)
    || (ctrl_type == qesm_pkg::CTRL_TVC_ENC);

  // registers
  always_comb
  begin
    next_cfg = cfg;
    next_ppr = ppr;
    next_dev = dev;
    next_dly = dly;
    next_calc = calc;
    next_irq_mask = irq_mask;
    next_irq_st = irq_st;
    next_rdata = 32'h0;
    if (bus_i.wr)
    begin
      case (bus_i.addr)
        qesm_pkg::ADDR_CFG: next_cfg = bus_i.wdata[11:0];
        qesm_pkg::ADDR_PPR: next_ppr = bus_i.wdata[15:0];
        qesm_pkg::ADDR_DEV: next_dev = bus_i.wdata[15:0];
        qesm_pkg::ADDR_DLY: next_dly = bus_i.wdata[15:0];
        qesm_pkg::ADDR_CALC: next_calc = bus_i.wdata[15:0];
        qesm_pkg::ADDR_IRQ: next_irq_st = irq_st & ~bus_i.wdata[2:0];
        qesm_pkg::ADDR_MASK: next_irq_mask = bus_i.wdata[2:0];
        default: next_cfg = cfg;
      endcase
    end
    // set wins over clear
    if (next_zero_flag)
      next_irq_st[qesm_pkg::IRQ_ZERO] = 1'b1;
    if (next_state == qesm_pkg::QESM_FAULT && state != qesm_pkg::QESM_FAULT)
      next_irq_st[qesm_pkg::IRQ_FAULT] = 1'b1;
    if (next_state == qesm_pkg::QESM_FALLBACK && state != qesm_pkg::QESM_FALLBACK)
      next_irq_st[qesm_pkg::IRQ_ALARM] = 1'b1;
    if (bus_i.rd)
    begin
      case (bus_i.addr)
        qesm_pkg::ADDR_CFG: next_rdata = {20'h0, cfg};
        qesm_pkg::ADDR_PPR: next_rdata = {16'h0, ppr};
        qesm_pkg::ADDR_DEV: next_rdata = {16'h0, dev};
        qesm_pkg::ADDR_DLY: next_rdata = {16'h0, dly};
        qesm_pkg::ADDR_CALC: next_rdata = {16'h0, calc};
        qesm_pkg::ADDR_SPEED: next_rdata = {16'h0, speed_o};
        qesm_pkg::ADDR_POS: next_rdata = pos;
        qesm_pkg::ADDR_STAT: next_rdata = {28'h0, use_encoder_o, 1'b0, state};
        qesm_pkg::ADDR_IRQ: next_rdata = {29'h0, irq_st};
        qesm_pkg::ADDR_MASK: next_rdata = {29'h0, irq_mask};
        default: next_rdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      cfg <= 12'h0;
      ppr <= qesm_pkg::PPR_RST;
      dev <= qesm_pkg::DEV_RST;
      dly <= qesm_pkg::DLY_RST;
      calc <= 16'h0;
      irq_st <= 3'h0;
      irq_mask <= 3'h0;
      rdata_o <= 32'h0;
    end
    else if (ce_i)
    begin
      cfg <= next_cfg;
      ppr <= next_ppr;
      dev <= next_dev;
      dly <= next_dly;
      calc <= next_calc;
      irq_st <= next_irq_st;
      irq_mask <= next_irq_mask;
      rdata_o <= next_rdata;
    end
  end

  assign irq_o = |(irq_st & irq_mask);

  // pin synchronisers; s1 read only by s2
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      s1 <= 3'h0;
      s2 <= 3'h0;
      s3 <= 3'h0;
    end
    else if (ce_i)
    begin
      s1 <= {zero_pulse_positive_i, track_b_positive_i, track_a_positive_i};
      s2 <= s1;
      s3 <= s2;
    end
  end

  // quadrature decode, speed gate
  always_comb
  begin
    step = (s2[0] ^ s3[0]) ^ (s2[1] ^ s3[1]);
    // a leading b: new a differs from old b
    dir_up = s2[0] ^ s3[1];
    next_pos = pos;
    next_win_cnt = win_cnt;
    next_gate = gate + 32'h1;
    next_speed = speed_o;
    sec_tick = gate == 32'(qesm_pkg::GATE_CYCLES - 1);
    if (!eval_on)
    begin
      next_pos = 32'sh0;
      next_win_cnt = 16'sh0;
      next_speed = 16'sh0;
    end
    else if (step)
    begin
      next_pos = dir_up ? pos + 32'sh1 : pos - 32'sh1;
      next_win_cnt = dir_up ? win_cnt + 16'sh1 : win_cnt - 16'sh1;
    end
    if (sec_tick)
    begin
      next_gate = 32'h0;
      // an edge on the tick cycle opens the next window
      if (eval_on && step)
        next_win_cnt = dir_up ? 16'sh1 : -16'sh1;
      else
        next_win_cnt = 16'sh0;
      // rpm = edges per gate * scale / ppr
      if (eval_on && ppr != 16'h0)
        next_speed = 16'(($signed(48'(win_cnt)) * 48'(qesm_pkg::SPEED_SCALE))
          / $signed({32'h0, ppr}));
      if (eval_on && ppr != 16'h0 && cfg[qesm_pkg::CFG_INV_BIT])
        next_speed = 16'(-(($signed(48'(win_cnt)) * 48'(qesm_pkg::SPEED_SCALE))
          / $signed({32'h0, ppr})));
    end
    next_zero_flag = zero_on && s2[2] && !s3[2];
  end

  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      pos <= 32'sh0;
      win_cnt <= 16'sh0;
      gate <= 32'h0;
      speed_o <= 16'sh0;
      zero_flag <= 1'b0;
    end
    else if (ce_i)
    begin
      pos <= next_pos;
      win_cnt <= next_win_cnt;
      gate <= next_gate;
      speed_o <= next_speed;
      zero_flag <= next_zero_flag;
    end
  end

  assign zero_flag_o = zero_flag;

  // loss monitor
  always_comb
  begin
    diff = 17'(speed_o) - 17'(calc);
    adiff = diff[16] ? 17'(-diff) : 17'(diff);
    loss = eval_on && ctrl_enc && (adiff > {1'b0, dev});
    next_state = state;
    next_dly_cnt = dly_cnt;
    case (state)
      qesm_pkg::QESM_RUN:
      begin
        next_dly_cnt = 16'h0;
        if (loss)
          next_state = qesm_pkg::QESM_PEND;
      end
      qesm_pkg::QESM_PEND:
      begin
        // delay counts gate periods
        if (!loss)
          next_state = qesm_pkg::QESM_RUN;
        else if (sec_tick && dly_cnt + 16'h1 >= dly)
          next_state = cfg[qesm_pkg::CFG_RESP_BIT] ? qesm_pkg::QESM_FALLBACK
            : qesm_pkg::QESM_FAULT;
        else if (sec_tick)
          next_dly_cnt = dly_cnt + 16'h1;
      end
      qesm_pkg::QESM_FAULT, qesm_pkg::QESM_FALLBACK:
      begin
        if (bus_i.wr && bus_i.addr == qesm_pkg::ADDR_CFG && bus_i.wdata[qesm_pkg::CFG_CLR_BIT])
          next_state = qesm_pkg::QESM_RUN;
      end
      default: next_state = qesm_pkg::QESM_RUN;
    endcase
  end

  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state <= qesm_pkg::QESM_RUN;
      dly_cnt <= 16'h0;
    end
    else if (ce_i)
    begin
      state <= next_state;
      dly_cnt <= next_dly_cnt;
    end
  end

  assign encoder_loss_fault_o = state == qesm_pkg::QESM_FAULT;
  assign alarm_o = state == qesm_pkg::QESM_FALLBACK;
  assign sensorless_vector_control_o = state == qesm_pkg::QESM_FALLBACK;
  assign use_encoder_o = eval_on && ctrl_enc && state != qesm_pkg::QESM_FALLBACK;
  assign encoder_vector_control_o = use_encoder_o;

  property p_fault_resp;
    @(posedge sys_clk_i) disable iff (rst_i)
    (ce_i && state == qesm_pkg::QESM_PEND && next_state != qesm_pkg::QESM_RUN
      && next_state != qesm_pkg::QESM_PEND && !cfg[qesm_pkg::CFG_RESP_BIT])
      |=> encoder_loss_fault_o;
  endproperty
  a_fault_resp: assert property (p_fault_resp) else $error("fault not raised");
  property p_alarm_resp;
    @(posedge sys_clk_i) disable iff (rst_i)
    alarm_o |-> sensorless_vector_control_o && !use_encoder_o && !encoder_loss_fault_o;
  endproperty
  a_alarm_resp: assert property (p_alarm_resp) else $error("fallback inconsistent");
  property p_use_enc;
    @(posedge sys_clk_i) disable iff (rst_i)
    use_encoder_o |-> (ctrl_type == qesm_pkg::CTRL_VC_ENC || ctrl_type == qesm_pkg::CTRL_TVC_ENC);
  endproperty
  a_use_enc: assert property (p_use_enc) else $error("encoder used in wrong mode");
  property p_off;
    @(posedge sys_clk_i) disable iff (rst_i)
    (ce_i && enc_type == qesm_pkg::TYPE_OFF) |=> (pos == 32'sh0 && speed_o == 16'sh0);
  endproperty
  a_off: assert property (p_off) else $error("evaluation not disabled");
  property p_zero;
    @(posedge sys_clk_i) disable iff (rst_i)
    (ce_i && zero_flag_o) |=> !zero_flag_o;
  endproperty
  a_zero: assert property (p_zero) else $error("zero flag too long");
  property p_count;
    @(posedge sys_clk_i) disable iff (rst_i)
    (ce_i && eval_on && step && dir_up) |=> pos == $past(pos) + 32'sh1;
  endproperty
  a_count: assert property (p_count) else $error("position not counted up");
  property p_loss_pend;
    @(posedge sys_clk_i) disable iff (rst_i)
    (ce_i && state == qesm_pkg::QESM_RUN && loss) |=> state == qesm_pkg::QESM_PEND;
  endproperty
  a_loss_pend: assert property (p_loss_pend) else $error("loss not seen");
  property p_delay;
    @(posedge sys_clk_i) disable iff (rst_i)
    (state == qesm_pkg::QESM_PEND && !sec_tick)
      |=> (state == qesm_pkg::QESM_RUN || state == qesm_pkg::QESM_PEND);
  endproperty
  a_delay: assert property (p_delay) else $error("response before delay");
  property p_fault_hold;
    @(posedge sys_clk_i) disable iff (rst_i)
    (state == qesm_pkg::QESM_FAULT && !bus_i.wr) |=> encoder_loss_fault_o;
  endproperty
  a_fault_hold: assert property (p_fault_hold) else $error("fault not latched");
  property p_fallback_hold;
    @(posedge sys_clk_i) disable iff (rst_i)
    (state == qesm_pkg::QESM_FALLBACK && !bus_i.wr)
      |=> (alarm_o && sensorless_vector_control_o);
  endproperty
  a_fallback_hold: assert property (p_fallback_hold) else $error("fallback not latched");
  property p_zero_off;
    @(posedge sys_clk_i) disable iff (rst_i)
    (ce_i && !zero_on) |=> !zero_flag_o;
  endproperty
  a_zero_off: assert property (p_zero_off) else $error("zero flag without zero track");
  property p_zero_irq;
    @(posedge sys_clk_i) disable iff (rst_i)
    (ce_i && next_zero_flag) |=> irq_st[qesm_pkg::IRQ_ZERO];
  endproperty
  a_zero_irq: assert property (p_zero_irq) else $error("zero status not set");
endmodule // qesm_top

// ==== dv/qesm_encoder_model.sv ====
`timescale 1ns/100ps
module qesm_encoder_model #(
  parameter int STEP = 100, // cycles per edge
  parameter int ZERO_EDGES = 400 // edges per revolution, multiple of 4
) (
  input wire logic sys_clk_i, // clock
  input wire logic en_i, // shaft turning
  output logic track_a_positive_o, // track a
  output logic track_b_positive_o, // track b
  output logic zero_pulse_positive_o // zero track
);
  int cnt = 0;
  int pos = 0;
  always @(posedge sys_clk_i)
  begin
    if (en_i)
    begin
      cnt <= (cnt == STEP - 1) ? 0 : cnt + 1;
      if (cnt == STEP - 1)
        pos <= (pos == ZERO_EDGES - 1) ? 0 : pos + 1;
    end
  end
  // gray steps 00,10,11,01: a leads b by a quarter period
  assign track_a_positive_o = pos[1] ^ pos[0];
  assign track_b_positive_o = pos[1];
  assign zero_pulse_positive_o = en_i && (pos == 0);
endmodule // qesm_encoder_model

// ==== dv/test_quadrature_encoder_speed_monitor.sv ====
`timescale 1ns/100ps
module test_quadrature_encoder_speed_monitor;
  logic sys_clk_i = 1'b0;
  logic rst_i = 1'b1;
  qesm_pkg::qesm_bus_t bus_i = '0;
  localparam int ENC_STEP = 100;
  logic enc_en = 1'b0;
  logic ce = 1'b1;
  logic a, b, z, use_enc, sensorless_vector_control, evc, fault, alarm, zflag, irq;
  logic [31:0] rdata_o, d, p1;
  logic signed [15:0] speed_o;
  logic [15:0] calc;
  int fail_count = 0;
  int check_count = 0;
  always #5 sys_clk_i = ~sys_clk_i;
  qesm_top uut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .ce_i(ce), .bus_i(bus_i),
    .rdata_o(rdata_o), .track_a_positive_i(a), .track_b_positive_i(b),
    .zero_pulse_positive_i(z), .speed_o(speed_o), .use_encoder_o(use_enc),
    .sensorless_vector_control_o(sensorless_vector_control), .encoder_vector_control_o(evc),
    .encoder_loss_fault_o(fault), .alarm_o(alarm), .zero_flag_o(zflag), .irq_o(irq));
  qesm_encoder_model #(.STEP(ENC_STEP)) enc (.sys_clk_i(sys_clk_i), .en_i(enc_en),
    .track_a_positive_o(a),
    .track_b_positive_o(b), .zero_pulse_positive_o(z));
  task automatic end_sim;
    $display("errors %0d checks %0d", fail_count, check_count);
    if (fail_count == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [3:0] adr, input logic [31:0] dat);
    @(posedge sys_clk_i);
    bus_i <= '{addr: adr, wdata: dat, wr: 1'b1, rd: 1'b0};
    @(posedge sys_clk_i);
    bus_i.wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [3:0] adr, output logic [31:0] dat);
    @(posedge sys_clk_i);
    bus_i <= '{addr: adr, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge sys_clk_i);
    bus_i.rd <= 1'b0;
    #1 dat = rdata_o;
  endtask
  // polls the state register, bounded to about two gate periods
  task automatic wait_state(input logic [1:0] s);
    d = {30'h0, ~s};
    for (int i = 0; i < qesm_pkg::GATE_CYCLES && d[1:0] !== s; i++)
      rd(qesm_pkg::ADDR_STAT, d);
  endtask
  function automatic logic [31:0] cfg(logic [3:0] t, logic [4:0] c, logic inv, logic resp,
                                      logic clr);
    return {20'h0, clr, resp, inv, c, t};
  endfunction
  // rpm from edges per gate: four edges per pulse
  function automatic int exp_rpm(int edges, int ppr, logic inv);
    longint r;
    r = longint'(edges) * 60 * qesm_pkg::CLK_HZ / (longint'(4 * ppr) * qesm_pkg::GATE_CYCLES);
    return inv ? -int'(r) : int'(r);
  endfunction
  initial
  begin
    int off;
    int sv;
    int rpm;
    off = $urandom(32'hd20f2ece);
    off = int'($urandom % 32'd81) - 40;
    repeat (5) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    rd(qesm_pkg::ADDR_PPR, d);
    chk("ppr reset", {16'h0, qesm_pkg::PPR_RST}, d);
    rd(qesm_pkg::ADDR_DEV, d);
    chk("deviation reset", {16'h0, qesm_pkg::DEV_RST}, d);
    rd(qesm_pkg::ADDR_DLY, d);
    chk("delay reset", {16'h0, qesm_pkg::DLY_RST}, d);
    rd(4'hf, d);
    chk("unmapped", 32'h0, d);
    calc = 16'(-10000 + off);
    wr(qesm_pkg::ADDR_PPR, 32'h5dc);
    wr(qesm_pkg::ADDR_DLY, 32'h1);
    // wide deviation while the first partial window settles
    wr(qesm_pkg::ADDR_DEV, 32'hffff);
    wr(qesm_pkg::ADDR_CALC, {{16{calc[15]}}, calc});
    wr(qesm_pkg::ADDR_MASK, 32'h1);
    wr(qesm_pkg::ADDR_CFG, cfg(qesm_pkg::TYPE_ABZ, qesm_pkg::CTRL_VC_ENC, 1'b1, 1'b0, 1'b0));
    enc_en <= 1'b1;
    chk("use encoder", 32'h1, {31'h0, use_enc});
    chk("encoder control", 32'h1, {31'h0, evc});
    for (int i = 0; i < 1000 && zflag !== 1'b1; i++)
      @(posedge sys_clk_i) #1;
    chk("zero flag", 32'h1, {31'h0, zflag});
    @(posedge sys_clk_i) #1;
    chk("zero flag pulse", 32'h0, {31'h0, zflag});
    repeat (2) @(posedge sys_clk_i);
    #1 chk("irq zero", 32'h1, {31'h0, irq});
    wr(qesm_pkg::ADDR_MASK, 32'h0);
    chk("irq masked", 32'h0, {31'h0, irq});
    wr(qesm_pkg::ADDR_IRQ, 32'h1);
    rd(qesm_pkg::ADDR_IRQ, d);
    chk("status cleared", 32'h0, {31'h0, d[0]});
    wr(qesm_pkg::ADDR_MASK, 32'h6);
    rd(qesm_pkg::ADDR_POS, p1);
    // clock enable low: position must stand still
    @(posedge sys_clk_i);
    ce <= 1'b0;
    repeat (1000) @(posedge sys_clk_i);
    ce <= 1'b1;
    rd(qesm_pkg::ADDR_POS, d);
    chk("frozen position", 32'h1, {31'h0, $signed(d - p1) < 3});
    p1 = d;
    repeat (1000) @(posedge sys_clk_i);
    rd(qesm_pkg::ADDR_POS, d);
    chk("position up", 32'h1, {31'h0, $signed(d - p1) > 0});
    for (int i = 0; i < 2 * qesm_pkg::GATE_CYCLES && speed_o === 16'sh0; i++)
      @(posedge sys_clk_i) #1;
    // first window is partial: take the next full one
    repeat (qesm_pkg::GATE_CYCLES) @(posedge sys_clk_i);
    #1 sv = speed_o;
    // full window at 1500 pulses, inverted
    rpm = exp_rpm(qesm_pkg::GATE_CYCLES / ENC_STEP, 1500, 1'b1);
    chk("speed", 32'h1, {31'h0, sv > rpm - 21 && sv < rpm + 21});
    wr(qesm_pkg::ADDR_DEV, {16'h0, qesm_pkg::DEV_RST});
    rd(qesm_pkg::ADDR_STAT, d);
    chk("run state", 32'h8, {28'h0, d[3:0]});
    wr(qesm_pkg::ADDR_CALC, 32'd10000);
    wait_state(qesm_pkg::QESM_PEND);
    chk("pending", {30'h0, qesm_pkg::QESM_PEND}, {30'h0, d[1:0]});
    chk("no early fault", 32'h0, {31'h0, fault});
    wait_state(qesm_pkg::QESM_FAULT);
    chk("fault", 32'h1, {31'h0, fault});
    chk("no alarm", 32'h0, {31'h0, alarm});
    chk("irq fault", 32'h1, {31'h0, irq});
    wr(qesm_pkg::ADDR_IRQ, 32'h2);
    chk("irq fault cleared", 32'h0, {31'h0, irq});
    wr(qesm_pkg::ADDR_CFG, cfg(qesm_pkg::TYPE_ABZ, qesm_pkg::CTRL_VC_ENC, 1'b1, 1'b1, 1'b1));
    wait_state(qesm_pkg::QESM_FALLBACK);
    chk("sensorless", 32'h1, {31'h0, sensorless_vector_control});
    chk("alarm", 32'h1, {31'h0, alarm});
    chk("fault gone", 32'h0, {31'h0, fault});
    chk("irq alarm", 32'h1, {31'h0, irq});
    wr(qesm_pkg::ADDR_CFG, cfg(qesm_pkg::TYPE_AB, 5'h14, 1'b0, 1'b1, 1'b1));
    chk("ctrl 20", 32'h0, {31'h0, use_enc});
    wr(qesm_pkg::ADDR_CFG, cfg(qesm_pkg::TYPE_OFF, qesm_pkg::CTRL_TVC_ENC, 1'b0, 1'b1, 1'b0));
    chk("type off", 32'h0, {31'h0, use_enc});
    wr(qesm_pkg::ADDR_CFG, cfg(qesm_pkg::TYPE_AB, qesm_pkg::CTRL_TVC_ENC, 1'b0, 1'b1, 1'b0));
    chk("type ab", 32'h1, {31'h0, use_enc});
    end_sim;
  end
  initial
  begin
    // about two and a half times the expected run
    #1000000;
    fail_count++;
    end_sim;
  end
endmodule // test_quadrature_encoder_speed_monitor
